// ### design/air_cipher_sync_mode_control.sv
// Functional notes
// - start clear, switch only at agreed frames
// - same 64 bit key loaded both sides
// - basic init value: frame, multiframe, zeros
// - advanced: bearer number and connection bits
// - reload generator every encrypted frame
// - 720 bits: fixed then portable half
// - portable decrypts fixed, encrypts portable half
// - duplex: both fields encrypted in mode
// - portable uses bearer number 15 first
// - portable tails even frames, never encrypted
// - only portable side initiates switches
// - begin request five even frames, confirm
// - no begin confirm: release, disconnect
// - decrypt from confirm frame, discard before
// - begin grant next even, encrypt onward
// - end request five even frames, timeout
// - end confirm frame clear, discard before
// - end grant next even, clear onward
`timescale 1ns/100ps
`default_nettype none
module air_cipher_sync_mode_control (
    input wire logic clk,
    input wire logic reset,
    // frame timing from the mac, pulse at each frame start
    input wire logic frame_start,
    input wire logic [3:0] frame_number,
    input wire logic [23:0] multiframe_number,
    input wire logic advanced,
    input wire logic first_bearer,
    input wire logic [3:0] logical_bearer_number,
    input wire logic [2:0] extended_connection_number,
    input wire logic [63:0] cipher_key,
    // one cycle request to toggle the cipher mode
    input wire logic cipher_switch_request_prim,
    // tail received in this frame, valid during rx_msg_valid pulse
    input wire logic rx_msg_valid,
    input wire air_cipher_pkg::rx_msg_type rx_msg,
    input wire logic keystream_bit_valid,
    output logic [63:0] keystream_key,
    output logic keystream_load,
    output logic [34:0] init_value,
    output logic keystream_fixed_segment,
    output logic keystream_portable_segment,
    output logic [8:0] keystream_bit_index,
    output logic [3:0] bearer_number_used,
    output air_cipher_pkg::tail_msg_type tx_msg,
    output logic tx_msg_encrypt,
    output logic tx_encrypt,
    output logic rx_decrypt,
    output logic rx_discard,
    output logic encrypt_mode,
    output logic cipher_switch_confirm_prim,
    output logic disconnect_indication_prim,
    output logic busy
);
    typedef enum logic [2:0] {
        st_clear,
        st_begin_wait,
        st_begin_grant,
        st_ciphered,
        st_end_wait,
        st_end_grant,
        st_released
    } mode_state_type;

    typedef struct packed {
        mode_state_type mode;
        logic pending;
        logic [2:0] repeats;
        air_cipher_pkg::tail_msg_type msg;
        logic tx_enc;
        logic rx_dec;
        logic discard;
        logic confirm;
        logic disconnect;
        logic [63:0] key;
        logic [3:0] bearer;
    } state_type;

    state_type s;
    state_type next_s;

    function automatic logic even_frame(input logic [3:0] number);
        even_frame = ~number[0];
    endfunction : even_frame

    logic even_now;
    logic frame_encrypted;

    assign even_now = even_frame(frame_number);

    always_comb begin
        next_s = s;
        next_s.confirm = 1'b0;
        next_s.disconnect = 1'b0;
        if (cipher_switch_request_prim && (s.mode == st_clear || s.mode == st_ciphered)) begin
            next_s.pending = 1'b1;
        end
        if (frame_start) begin
            next_s.key = cipher_key;
            next_s.bearer = first_bearer ? air_cipher_pkg::first_bearer_number
                : logical_bearer_number;
            next_s.msg = air_cipher_pkg::msg_none;
            if (even_now) begin
                case (s.mode)
                    st_clear: begin
                        if (s.pending) begin
                            next_s.pending = 1'b0;
                            next_s.mode = st_begin_wait;
                            next_s.repeats = 3'h1;
                            next_s.msg = air_cipher_pkg::msg_begin_request;
                            next_s.discard = 1'b1;
                        end
                    end
                    st_begin_wait: begin
                        if (s.repeats == air_cipher_pkg::request_repeats) begin
                            next_s.mode = st_released;
                            next_s.disconnect = 1'b1;
                            next_s.discard = 1'b0;
                        end else begin
                            next_s.repeats = s.repeats + 3'h1;
                            next_s.msg = air_cipher_pkg::msg_begin_request;
                        end
                    end
                    st_begin_grant: begin
                        next_s.msg = air_cipher_pkg::msg_begin_grant;
                        next_s.tx_enc = 1'b1;
                        next_s.mode = st_ciphered;
                    end
                    st_ciphered: begin
                        if (s.pending) begin
                            next_s.pending = 1'b0;
                            next_s.mode = st_end_wait;
                            next_s.repeats = 3'h1;
                            next_s.msg = air_cipher_pkg::msg_end_request;
                            next_s.discard = 1'b1;
                        end
                    end
                    st_end_wait: begin
                        if (s.repeats == air_cipher_pkg::request_repeats) begin
                            next_s.mode = st_released;
                            next_s.disconnect = 1'b1;
                            next_s.discard = 1'b0;
                        end else begin
                            next_s.repeats = s.repeats + 3'h1;
                            next_s.msg = air_cipher_pkg::msg_end_request;
                        end
                    end
                    st_end_grant: begin
                        next_s.msg = air_cipher_pkg::msg_end_grant;
                        next_s.tx_enc = 1'b0;
                        next_s.mode = st_clear;
                    end
                    st_released: begin
                        next_s.pending = 1'b0;
                    end
                    default: begin
                        next_s.mode = st_clear;
                    end
                endcase
            end
        end
        // confirms from the fixed side arrive in odd frames
        if (rx_msg_valid) begin
            if (s.mode == st_begin_wait && rx_msg == air_cipher_pkg::rx_begin_confirm) begin
                next_s.mode = st_begin_grant;
                next_s.rx_dec = 1'b1;
                next_s.discard = 1'b0;
                next_s.confirm = 1'b1;
            end else if (s.mode == st_end_wait && rx_msg == air_cipher_pkg::rx_end_confirm) begin
                next_s.mode = st_end_grant;
                next_s.rx_dec = 1'b0;
                next_s.discard = 1'b0;
                next_s.confirm = 1'b1;
            end
        end
        if (reset) begin
            next_s = '0;
            next_s.mode = st_clear;
            next_s.msg = air_cipher_pkg::msg_none;
            next_s.bearer = air_cipher_pkg::first_bearer_number;
        end
    end

    always_ff @(posedge clk) begin
        s <= next_s;
    end

    // generator runs for any frame where either direction is ciphered
    assign frame_encrypted = next_s.tx_enc || next_s.rx_dec
        || (s.mode == st_begin_wait) || (s.mode == st_begin_grant);

    keystream_loader loader (
        .clk(clk),
        .reset(reset),
        .frame_start(frame_start),
        .encrypt_frame(frame_encrypted),
        .advanced(advanced),
        .frame_number(frame_number),
        .multiframe_number(multiframe_number),
        .logical_bearer_number(next_s.bearer),
        .extended_connection_number(extended_connection_number),
        .keystream_bit_valid(keystream_bit_valid),
        .keystream_load(keystream_load),
        .init_value(init_value),
        .keystream_fixed_segment(keystream_fixed_segment),
        .keystream_portable_segment(keystream_portable_segment),
        .keystream_bit_index(keystream_bit_index)
    );

    assign keystream_key = s.key;
    assign bearer_number_used = s.bearer;
    assign tx_msg = s.msg;
    assign tx_msg_encrypt = 1'b0;
    // transmit uses portable half, receive uses fixed half
    assign tx_encrypt = s.tx_enc && keystream_portable_segment;
    assign rx_decrypt = s.rx_dec && keystream_fixed_segment;
    assign rx_discard = s.discard;
    assign encrypt_mode = s.tx_enc;
    assign cipher_switch_confirm_prim = s.confirm;
    assign disconnect_indication_prim = s.disconnect;
    assign busy = s.mode != st_clear && s.mode != st_ciphered;
endmodule : air_cipher_sync_mode_control
`default_nettype wire

// ### design/air_cipher_pkg.sv
package air_cipher_pkg;
    localparam int key_width = 64;
    localparam int init_width = 35;
    localparam int frame_lsb = 0;
    localparam int frame_width = 4;
    localparam int multiframe_lsb = 4;
    localparam int multiframe_width = 24;
    localparam int bearer_lsb = 28;
    localparam int bearer_width = 4;
    localparam int conn_lsb = 32;
    localparam int conn_width = 3;
    localparam logic [3:0] first_bearer_number = 4'hf;
    localparam int segment_bits = 360;
    localparam int pair_bits = 720;
    localparam logic [2:0] request_repeats = 3'h5;
    localparam logic [9:0] pair_bits_last = 10'h2cf;
    localparam logic [9:0] segment_bits_last = 10'h167;

    typedef enum logic [2:0] {
        msg_none,
        msg_begin_request,
        msg_begin_grant,
        msg_end_request,
        msg_end_grant
    } tail_msg_type;

    typedef enum logic [1:0] {
        rx_none,
        rx_begin_confirm,
        rx_end_confirm
    } rx_msg_type;
endpackage : air_cipher_pkg

// ### design/keystream_loader.sv
`timescale 1ns/100ps
`default_nettype none
// builds the frame init value and sequences the 720 bit stream
module keystream_loader (
    input wire logic clk,
    input wire logic reset,
    input wire logic frame_start,
    input wire logic encrypt_frame,
    input wire logic advanced,
    input wire logic [3:0] frame_number,
    input wire logic [23:0] multiframe_number,
    input wire logic [3:0] logical_bearer_number,
    input wire logic [2:0] extended_connection_number,
    input wire logic keystream_bit_valid,
    output logic keystream_load,
    output logic [34:0] init_value,
    output logic keystream_fixed_segment,
    output logic keystream_portable_segment,
    output logic [8:0] keystream_bit_index
);
    typedef struct packed {
        logic load;
        logic [34:0] iv;
        logic running;
        logic [9:0] count;
    } state_type;

    state_type s;
    state_type next_s;

    always_comb begin
        next_s = s;
        next_s.load = 1'b0;
        if (frame_start && encrypt_frame) begin
            next_s.load = 1'b1;
            next_s.running = 1'b1;
            next_s.count = 10'h000;
            next_s.iv = '0;
            next_s.iv[air_cipher_pkg::frame_lsb +: air_cipher_pkg::frame_width] =
                frame_number;
            next_s.iv[air_cipher_pkg::multiframe_lsb +: air_cipher_pkg::multiframe_width] =
                multiframe_number;
            if (advanced) begin
                next_s.iv[air_cipher_pkg::bearer_lsb +: air_cipher_pkg::bearer_width] =
                    logical_bearer_number;
                next_s.iv[air_cipher_pkg::conn_lsb +: air_cipher_pkg::conn_width] =
                    extended_connection_number;
            end
        end else if (s.running && keystream_bit_valid) begin
            if (s.count == air_cipher_pkg::pair_bits_last) begin
                next_s.running = 1'b0;
            end
            next_s.count = s.count + 10'h001;
        end
        if (reset) begin
            next_s = '0;
        end
    end

    always_ff @(posedge clk) begin
        s <= next_s;
    end

    assign keystream_load = s.load;
    assign init_value = s.iv;
    // first half fixed segment, second half portable segment
    assign keystream_fixed_segment = s.running && (s.count <= air_cipher_pkg::segment_bits_last);
    assign keystream_portable_segment = s.running && (s.count > air_cipher_pkg::segment_bits_last);
    assign keystream_bit_index = keystream_portable_segment ?
        9'(s.count - 10'(air_cipher_pkg::segment_bits)) : s.count[8:0];
endmodule : keystream_loader
`default_nettype wire

// ### bench/air_cipher_properties.sv
`timescale 1ns/100ps
`default_nettype none
module air_cipher_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic frame_start,
    input wire logic [3:0] frame_number,
    input wire logic [23:0] multiframe_number,
    input wire logic advanced,
    input wire logic [2:0] extended_connection_number,
    input wire logic [63:0] cipher_key,
    input wire logic rx_msg_valid,
    input wire logic [63:0] keystream_key,
    input wire logic keystream_load,
    input wire logic [34:0] init_value,
    input wire logic keystream_fixed_segment,
    input wire logic keystream_portable_segment,
    input wire logic [3:0] bearer_number_used,
    input wire air_cipher_pkg::tail_msg_type tx_msg,
    input wire logic tx_msg_encrypt,
    input wire logic tx_encrypt,
    input wire logic encrypt_mode,
    input wire logic cipher_switch_confirm_prim,
    input wire logic disconnect_indication_prim,
    input wire logic busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_tail_even; $changed(tx_msg) && tx_msg != air_cipher_pkg::msg_none
        |-> $past(frame_start) && !$past(frame_number[0]); endproperty
    a_tail_even: assert property (p_tail_even) else $error("tail outside even frame");
    property p_tail_clear; tx_msg != air_cipher_pkg::msg_none |-> !tx_msg_encrypt; endproperty
    a_tail_clear: assert property (p_tail_clear) else $error("tail encrypted");
    property p_confirm; cipher_switch_confirm_prim |-> $past(rx_msg_valid) ##1 !cipher_switch_confirm_prim; endproperty
    a_confirm: assert property (p_confirm) else $error("bad confirm pulse");
    property p_release; disconnect_indication_prim |=> busy [*8]; endproperty
    a_release: assert property (p_release) else $error("release not held");
    property p_iv_frame; keystream_load |-> $past(frame_start)
        && init_value[27:0] == {$past(multiframe_number), $past(frame_number)}; endproperty
    a_iv_frame: assert property (p_iv_frame) else $error("init value frame bits wrong");
    property p_iv_upper; keystream_load |-> init_value[34:28]
        == (advanced ? {extended_connection_number, bearer_number_used} : 7'h00); endproperty
    a_iv_upper: assert property (p_iv_upper) else $error("init value upper bits wrong");
    property p_key; frame_start |=> keystream_key == $past(cipher_key); endproperty
    a_key: assert property (p_key) else $error("key not loaded");
    property p_tx_half; tx_encrypt |-> encrypt_mode && keystream_portable_segment
        && !keystream_fixed_segment; endproperty
    a_tx_half: assert property (p_tx_half) else $error("tx uses wrong half");
endmodule : air_cipher_checker
`default_nettype wire

// ### bench/fixed_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module fixed_side_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic frame_start,
    input wire logic [3:0] frame_number,
    input wire air_cipher_pkg::tail_msg_type tx_msg,
    input wire logic mute,
    input wire logic [2:0] lag,
    output logic rx_msg_valid,
    output air_cipher_pkg::rx_msg_type rx_msg
);
    air_cipher_pkg::rx_msg_type kind;
    logic [3:0] sent;
    // never starts a switch on its own, only answers
    always @(negedge clk) begin
        rx_msg_valid <= 1'b0;
        rx_msg <= air_cipher_pkg::rx_none;
        if (reset || tx_msg == air_cipher_pkg::msg_begin_grant
                || tx_msg == air_cipher_pkg::msg_end_grant) begin
            kind <= air_cipher_pkg::rx_none;
            sent <= 4'h0;
        end else if (frame_start && frame_number[0] && kind != air_cipher_pkg::rx_none
                && sent < 4'h6) begin
            sent <= sent + 4'h1;
            if (!mute && sent >= {1'b0, lag}) begin
                rx_msg_valid <= 1'b1;
                rx_msg <= kind;
            end
        end else if (kind == air_cipher_pkg::rx_none && tx_msg == air_cipher_pkg::msg_begin_request)
            kind <= air_cipher_pkg::rx_begin_confirm;
        else if (kind == air_cipher_pkg::rx_none && tx_msg == air_cipher_pkg::msg_end_request)
            kind <= air_cipher_pkg::rx_end_confirm;
    end
endmodule : fixed_side_model
`default_nettype wire

// ### bench/air_cipher_sync_mode_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module air_cipher_sync_mode_control_tb_top;
    logic clk, reset, frame_start, advanced, first_bearer, cipher_switch_request_prim;
    logic rx_msg_valid, keystream_bit_valid, keystream_load, keystream_fixed_segment, mute;
    logic keystream_portable_segment, tx_msg_encrypt, tx_encrypt, rx_decrypt, rx_discard, busy;
    logic encrypt_mode, cipher_switch_confirm_prim, disconnect_indication_prim;
    logic [3:0] frame_number, logical_bearer_number, bearer_number_used;
    logic [23:0] multiframe_number;
    logic [2:0] extended_connection_number, lag;
    logic [63:0] cipher_key, keystream_key;
    logic [34:0] init_value;
    logic [8:0] keystream_bit_index;
    air_cipher_pkg::rx_msg_type rx_msg;
    air_cipher_pkg::tail_msg_type tx_msg, prev_msg;
    int err_total, checks_done, cyc, n_req, n_conf, n_disc, i;
    // bit position the generator should be at, pair_bits when idle
    int kbit = air_cipher_pkg::pair_bits;

    air_cipher_sync_mode_control uut (.*);
    fixed_side_model far_end (.*);

    always #4 clk = ~clk;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    task automatic check(input logic [34:0] got, input logic [34:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    function automatic logic [34:0] iv_exp();
        iv_exp = {advanced ? {extended_connection_number, first_bearer ? 4'hf
            : logical_bearer_number} : 7'h00, multiframe_number, frame_number};
    endfunction : iv_exp

    // frame timing, random stream inputs and output monitor
    always @(negedge clk) begin
        cyc <= cyc + 1;
        frame_start <= (cyc[4:0] == 5'h1f);
        keystream_bit_valid <= 1'($urandom_range(1));
        if (cyc[4:0] == 5'h1f) begin
            frame_number <= frame_number + 4'h1;
            cipher_key <= {$urandom, $urandom};
            if (frame_number == 4'hf)
                multiframe_number <= multiframe_number + 24'h1;
        end
        if (tx_msg != prev_msg && (tx_msg == air_cipher_pkg::msg_begin_request
                || tx_msg == air_cipher_pkg::msg_end_request))
            n_req++;
        prev_msg = tx_msg;
        n_conf += int'(cipher_switch_confirm_prim);
        n_disc += int'(disconnect_indication_prim);
        if (keystream_load === 1'b1)
            kbit = 0;
        else if (kbit < air_cipher_pkg::pair_bits && keystream_bit_valid)
            kbit++;
        if (!reset) begin
            check(keystream_fixed_segment, 35'(kbit < air_cipher_pkg::segment_bits));
            check(keystream_portable_segment, 35'(kbit >= air_cipher_pkg::segment_bits
                && kbit < air_cipher_pkg::pair_bits));
            if (kbit < air_cipher_pkg::pair_bits)
                check(keystream_bit_index, 35'(kbit % air_cipher_pkg::segment_bits));
        end
        if (keystream_load === 1'b1 && !reset)
            check(init_value, iv_exp());
        if (cyc == 12000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic switch_mode(input logic want, input logic ok);
        int k;
        n_req = 0;
        n_conf = 0;
        n_disc = 0;
        cipher_switch_request_prim <= 1'b1;
        @(negedge clk);
        cipher_switch_request_prim <= 1'b0;
        for (k = 0; k < 600 && encrypt_mode !== want && n_disc == 0; k++)
            @(negedge clk);
        check(encrypt_mode, ok ? want : !want);
        check(n_req, ok ? 35'(lag) + 35'h1 : 35'h5);
        check(n_conf, 35'(ok));
        check(n_disc, 35'(!ok));
        if (ok)
            check(tx_msg, want ? air_cipher_pkg::msg_begin_grant : air_cipher_pkg::msg_end_grant);
        if (ok)
            check(rx_discard, 1'b0);
        check(rx_decrypt, 35'(want && ok && keystream_fixed_segment));
        check(tx_encrypt, 35'(want && ok && keystream_portable_segment));
        $display("test done want %0d ok %0d lag %0d", want, ok, lag);
        @(negedge clk);
    endtask : switch_mode

    initial begin
        {clk, frame_start, advanced, first_bearer, cipher_switch_request_prim, mute} = '0;
        {keystream_bit_valid, frame_number, multiframe_number, lag, cyc} = '0;
        {logical_bearer_number, extended_connection_number, cipher_key} = '0;
        {err_total, checks_done, n_req, n_conf, n_disc} = '0;
        prev_msg = air_cipher_pkg::msg_none;
        reset = 1'b1;
        void'($urandom(32'h2ca6da26));
        multiframe_number = 24'($urandom);
        repeat (16) @(negedge clk);
        reset <= 1'b0;
        @(negedge clk);
        check(encrypt_mode, 1'b0);
        check(tx_msg, air_cipher_pkg::msg_none);
        check(bearer_number_used, 4'hf);
        for (i = 0; i < 4; i++) begin
            advanced <= i[0];
            first_bearer <= i[1];
            logical_bearer_number <= 4'($urandom);
            extended_connection_number <= 3'($urandom);
            lag <= (i == 3) ? 3'h4 : 3'($urandom_range(3));
            @(negedge clk);
            switch_mode(1'b1, 1'b1);
            check(bearer_number_used, first_bearer ? 4'hf : logical_bearer_number);
            switch_mode(1'b0, 1'b1);
        end
        mute <= 1'b1;
        @(negedge clk);
        switch_mode(1'b1, 1'b0);
        // long idle lets a started stream run through both halves
        repeat (1600) @(negedge clk);
        check(busy, 1'b1);
        check(encrypt_mode, 1'b0);
        end_sim();
    end
endmodule : air_cipher_sync_mode_control_tb_top

bind air_cipher_sync_mode_control air_cipher_checker chk (.*);
`default_nettype wire
